// ===== hdl/arith_coder_host_control_regs.sv
// Purpose: Host control registers of the arithmetic coder
// Assumes: Host strobes are synchronous one-cycle pulses on clock
// Notes: Core-side events arrive as one-cycle pulses or levels on clock
//
// Summary of operation
// - Enable bits 0..3 gate status bits 0..3 onto the interrupt.
// - Done enable also raises interrupt at temporary stop, done status stays zero.
// - Interrupt drops once every enabled cause is cleared or masked.
// - Interrupt and enable register access never clear status bits.
// - Marker pause bit stops decoding at a marker; marker interrupt if enabled.
// - Host may rewrite line count in pause; clearing pause resumes decoding.
// - Line count is relative to each start; processing stops on reaching it.
// - Read-only processed line count, cleared by start.
// - After table transfer command, bytes move through the buffer register.
// - Table of 1024 words, low then high byte, address steps per word.
// - Entry holds predicted symbol in bit 15, probability in bits 14..0.
// - Two-bit mode selects coding, decoding or either through direction.
// - Line-memory load/store bits act only in through modes.
// - Read-through field discards leading code bytes at first-stripe decode.
// - Interrupt-relevant status bits are done, ready, marker and overflow.
// - Start runs the selected mode and self-clears at final end.
`timescale 1ns/1ps
module arith_coder_host_control_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  input wire logic start_cmd,
  input wire logic pause_select,
  input wire logic table_transfer_command,
  input wire arith_coder_pkg::core_events_t core_events,
  input wire logic status_clear,
  input wire logic line_step,
  input wire logic marker_seen,
  input wire logic code_byte_valid,
  output logic irq_out,
  output logic run_command,
  output logic decode_hold,
  output logic line_limit_reached,
  output logic code_byte_discard,
  output arith_coder_pkg::operation_mode_t mode_out,
  output logic [13:0] pixels_per_line,
  output logic [15:0] line_target,
  output logic [3:0] status_bits
);

  // ==========================================================================
  // Register state
  arith_coder_pkg::interrupt_enable_t ien_r, ien_nxt;
  arith_coder_pkg::operation_mode_t mode_r, mode_nxt;
  logic [7:0] pel_low_r, pel_low_nxt;
  logic [5:0] pel_high_r, pel_high_nxt;
  logic [15:0] lset_r, lset_nxt;
  logic [15:0] lines_r, lines_nxt;
  logic done_r, done_nxt;
  logic ready_r, ready_nxt;
  logic marker_r, marker_nxt;
  logic stuff_r, stuff_nxt;
  logic tstop_r, tstop_nxt;
  logic run_r, run_nxt;
  logic hold_r, hold_nxt;
  logic limit_r, limit_nxt;
  logic [1:0] skip_r, skip_nxt;
  logic discard_r, discard_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // ==========================================================================
  // Context table path
  typedef enum {tbl_low, tbl_high} tbl_state_t;
  tbl_state_t tbl_r, tbl_nxt;
  logic [9:0] tbl_addr_r, tbl_addr_nxt;
  logic [7:0] tbl_low_r, tbl_low_nxt;
  logic tbl_wr;
  logic [15:0] tbl_rd;
  logic buf_access;

  context_table_ram #(
    .depth(arith_coder_pkg::table_depth),
    .addr_width(arith_coder_pkg::table_addr_width)
  ) u_ram (
    .clock(clock),
    .wr_en(tbl_wr),
    .addr(tbl_addr_r),
    .wr_data({host_wdata, tbl_low_r}),
    .rd_data(tbl_rd)
  );

  assign buf_access = table_transfer_command && (host_addr == arith_coder_pkg::off_context_table_buffer);

  always_comb
  begin
    tbl_nxt = tbl_r;
    tbl_addr_nxt = tbl_addr_r;
    tbl_low_nxt = tbl_low_r;
    tbl_wr = 1'b0;
    if (!table_transfer_command)
    begin
      tbl_nxt = tbl_low;
      tbl_addr_nxt = 10'h000;
    end
    else if (buf_access && (host_wr || host_rd))
    begin
      case (tbl_r)
        tbl_low:
        begin
          if (host_wr)
          begin
            tbl_low_nxt = host_wdata;
          end
          tbl_nxt = tbl_high;
        end
        tbl_high:
        begin
          // Word write lands with high byte; bit 15 predicted symbol
          tbl_wr = host_wr;
          tbl_nxt = tbl_low;
          tbl_addr_nxt = tbl_addr_r + 10'h001;
        end
        default:
        begin
          tbl_nxt = tbl_low;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tbl_r <= tbl_low;
      tbl_addr_r <= 10'h000;
      tbl_low_r <= 8'h00;
    end
    else
    begin
      tbl_r <= tbl_nxt;
      tbl_addr_r <= tbl_addr_nxt;
      tbl_low_r <= tbl_low_nxt;
    end
  end

  // ==========================================================================
  // Control and status
  always_comb
  begin
    ien_nxt = ien_r;
    mode_nxt = mode_r;
    pel_low_nxt = pel_low_r;
    pel_high_nxt = pel_high_r;
    lset_nxt = lset_r;
    lines_nxt = lines_r;
    done_nxt = done_r;
    ready_nxt = core_events.data_ready;
    marker_nxt = marker_r;
    stuff_nxt = stuff_r;
    tstop_nxt = tstop_r;
    run_nxt = run_r;
    hold_nxt = hold_r;
    limit_nxt = 1'b0;
    skip_nxt = skip_r;
    discard_nxt = 1'b0;
    if (host_wr)
    begin
      if (host_addr == arith_coder_pkg::off_interrupt_enable)
      begin
        ien_nxt = host_wdata;
        ien_nxt.unused = 3'h0;
      end
      else if (host_addr == arith_coder_pkg::off_pixels_per_line_low)
      begin
        pel_low_nxt = host_wdata;
      end
      else if (host_addr == arith_coder_pkg::off_pixels_per_line_high)
      begin
        pel_high_nxt = host_wdata[5:0];
      end
      else if (host_addr == arith_coder_pkg::off_line_count_set_low)
      begin
        lset_nxt[7:0] = host_wdata;
      end
      else if (host_addr == arith_coder_pkg::off_line_count_set_high)
      begin
        lset_nxt[15:8] = host_wdata;
      end
      else if (host_addr == arith_coder_pkg::off_operation_mode)
      begin
        mode_nxt = host_wdata;
      end
    end
    if (status_clear)
    begin
      done_nxt = 1'b0;
      marker_nxt = 1'b0;
      stuff_nxt = 1'b0;
      tstop_nxt = 1'b0;
    end
    if (start_cmd)
    begin
      lines_nxt = arith_coder_pkg::reset_word;
      run_nxt = 1'b1;
      tstop_nxt = 1'b0;
      done_nxt = 1'b0;
      hold_nxt = 1'b0;
      if (mode_r.op_select == arith_coder_pkg::op_decoding)
      begin
        skip_nxt = mode_r.readthrough_bytes;
      end
    end
    else if (run_r && !hold_r && !tstop_r && line_step)
    begin
      lines_nxt = lines_r + 16'h0001;
      if (lines_r + 16'h0001 == lset_r)
      begin
        limit_nxt = 1'b1;
        if (pause_select)
        begin
          tstop_nxt = 1'b1;
        end
        else
        begin
          run_nxt = 1'b0;
        end
      end
    end
    if (code_byte_valid && skip_r != 2'h0)
    begin
      skip_nxt = skip_r - 2'h1;
      discard_nxt = 1'b1;
    end
    if (run_r && mode_r.op_select == arith_coder_pkg::op_decoding && ien_r.marker_pause && marker_seen)
    begin
      hold_nxt = 1'b1;
    end
    else if (!ien_r.marker_pause)
    begin
      hold_nxt = 1'b0;
    end
    // Events set after clears so a same-cycle set wins
    if (core_events.done)
    begin
      done_nxt = 1'b1;
      run_nxt = 1'b0;
    end
    if (core_events.marker_found || marker_seen)
    begin
      marker_nxt = 1'b1;
    end
    if (core_events.stuff_overflow)
    begin
      stuff_nxt = 1'b1;
    end
    if (core_events.temp_stop)
    begin
      tstop_nxt = 1'b1;
    end
    // Enabled causes only; no status bit is touched here
    irq_nxt = (ien_nxt.done_irq_enable && (done_nxt || tstop_nxt))
           || (ien_nxt.data_ready_irq_enable && ready_nxt)
           || (ien_nxt.marker_irq_enable && marker_nxt)
           || (ien_nxt.stuff_overflow_irq_enable && stuff_nxt);
  end

  // ==========================================================================
  // Read mux
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (host_addr == arith_coder_pkg::off_interrupt_enable)
    begin
      rdata_nxt = ien_r;
    end
    else if (host_addr == arith_coder_pkg::off_pixels_per_line_low)
    begin
      rdata_nxt = pel_low_r;
    end
    else if (host_addr == arith_coder_pkg::off_pixels_per_line_high)
    begin
      rdata_nxt = {2'h0, pel_high_r};
    end
    else if (host_addr == arith_coder_pkg::off_line_count_set_low)
    begin
      rdata_nxt = lset_r[7:0];
    end
    else if (host_addr == arith_coder_pkg::off_line_count_set_high)
    begin
      rdata_nxt = lset_r[15:8];
    end
    else if (host_addr == arith_coder_pkg::off_lines_done_low)
    begin
      rdata_nxt = lines_r[7:0];
    end
    else if (host_addr == arith_coder_pkg::off_lines_done_high)
    begin
      rdata_nxt = lines_r[15:8];
    end
    else if (host_addr == arith_coder_pkg::off_context_table_buffer)
    begin
      // RAM data is one cycle old; host reads low byte first
      rdata_nxt = (tbl_r == tbl_low) ? tbl_rd[7:0] : tbl_rd[15:8];
    end
    else if (host_addr == arith_coder_pkg::off_operation_mode)
    begin
      rdata_nxt = mode_r;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ien_r <= arith_coder_pkg::reset_byte;
      mode_r <= arith_coder_pkg::reset_byte;
      pel_low_r <= 8'h00;
      pel_high_r <= 6'h00;
      lset_r <= arith_coder_pkg::reset_word;
      lines_r <= arith_coder_pkg::reset_word;
      done_r <= 1'b0;
      ready_r <= 1'b0;
      marker_r <= 1'b0;
      stuff_r <= 1'b0;
      tstop_r <= 1'b0;
      run_r <= 1'b0;
      hold_r <= 1'b0;
      limit_r <= 1'b0;
      skip_r <= 2'h0;
      discard_r <= 1'b0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ien_r <= ien_nxt;
      mode_r <= mode_nxt;
      pel_low_r <= pel_low_nxt;
      pel_high_r <= pel_high_nxt;
      lset_r <= lset_nxt;
      lines_r <= lines_nxt;
      done_r <= done_nxt;
      ready_r <= ready_nxt;
      marker_r <= marker_nxt;
      stuff_r <= stuff_nxt;
      tstop_r <= tstop_nxt;
      run_r <= run_nxt;
      hold_r <= hold_nxt;
      limit_r <= limit_nxt;
      skip_r <= skip_nxt;
      discard_r <= discard_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign host_rdata = rdata_r;
  assign irq_out = irq_r;
  assign run_command = run_r;
  assign decode_hold = hold_r;
  assign line_limit_reached = limit_r;
  assign code_byte_discard = discard_r;
  assign mode_out = mode_r;
  assign pixels_per_line = {pel_high_r, pel_low_r};
  assign line_target = lset_r;
  assign status_bits = {stuff_r, marker_r, ready_r, done_r};

  // ==========================================================================
  // Checks
  sequence s_limit_hit;
    run_r && !hold_r && !tstop_r && line_step && !start_cmd && (lines_r + 16'h0001 == lset_r);
  endsequence

  property p_irq_tracks_causes;
    @(posedge clock) disable iff (rst)
    ((ien_r.done_irq_enable && (done_r || tstop_r)) || (ien_r.marker_irq_enable && marker_r)
      || (ien_r.stuff_overflow_irq_enable && stuff_r) || (ien_r.data_ready_irq_enable && ready_r)) == irq_r;
  endproperty
  a_irq_tracks_causes: assert property (p_irq_tracks_causes) else $error("irq does not match causes");

  property p_tstop_irq;
    @(posedge clock) disable iff (rst)
    (ien_r.done_irq_enable && tstop_r) |-> irq_r && !done_r;
  endproperty
  a_tstop_irq: assert property (p_tstop_irq) else $error("no irq at temporary stop");

  property p_masked_drop;
    @(posedge clock) disable iff (rst)
    (ien_r[3:0] == 4'h0) |-> !irq_r;
  endproperty
  a_masked_drop: assert property (p_masked_drop) else $error("irq with all causes masked");

  property p_ien_write_keeps_status;
    @(posedge clock) disable iff (rst)
    (host_wr && host_addr == arith_coder_pkg::off_interrupt_enable && !status_clear && !start_cmd)
      |=> (marker_r || !$past(marker_r)) && (stuff_r || !$past(stuff_r));
  endproperty
  a_ien_write_keeps_status: assert property (p_ien_write_keeps_status) else $error("status lost on enable write");

  property p_marker_hold;
    @(posedge clock) disable iff (rst)
    (run_r && mode_r.op_select == arith_coder_pkg::op_decoding && ien_r.marker_pause && marker_seen) |=> hold_r;
  endproperty
  a_marker_hold: assert property (p_marker_hold) else $error("decode not held at marker");

  property p_resume;
    @(posedge clock) disable iff (rst)
    (hold_r && !ien_r.marker_pause && !marker_seen) |=> !hold_r;
  endproperty
  a_resume: assert property (p_resume) else $error("decode not resumed");

  property p_limit_stop;
    @(posedge clock) disable iff (rst)
    (s_limit_hit and !pause_select and !core_events.done) |=> line_limit_reached && !run_r;
  endproperty
  a_limit_stop: assert property (p_limit_stop) else $error("run not ended at line count");

  property p_start_clears;
    @(posedge clock) disable iff (rst)
    start_cmd |=> lines_r == 16'h0000 && run_r;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("start did not clear line counter");

  property p_addr_step;
    @(posedge clock) disable iff (rst)
    (table_transfer_command && tbl_r == tbl_high && buf_access && (host_wr || host_rd))
      |=> tbl_addr_r == $past(tbl_addr_r) + 10'h001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("table address did not advance");

  property p_skip_discard;
    @(posedge clock) disable iff (rst)
    (code_byte_valid && skip_r != 2'h0) |=> code_byte_discard ##0 (skip_r == $past(skip_r) - 2'h1 || $past(start_cmd));
  endproperty
  a_skip_discard: assert property (p_skip_discard) else $error("read-through byte not discarded");

endmodule

// ===== hdl/arith_coder_pkg.sv
// Purpose: Shared constants and types for the coder host control registers
// Assumes: 8-bit host bus, 4-bit register address
// Notes: Offsets are byte addresses on the host bus
package arith_coder_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [3:0] off_interrupt_enable = 4'h3;
  localparam logic [3:0] off_pixels_per_line_low = 4'h4;
  localparam logic [3:0] off_pixels_per_line_high = 4'h5;
  localparam logic [3:0] off_line_count_set_low = 4'h6;
  localparam logic [3:0] off_line_count_set_high = 4'h7;
  localparam logic [3:0] off_lines_done_low = 4'h8;
  localparam logic [3:0] off_lines_done_high = 4'h9;
  localparam logic [3:0] off_context_table_buffer = 4'ha;
  localparam logic [3:0] off_operation_mode = 4'hb;

  // ==========================================================================
  // Field positions
  localparam int done_irq_enable_pos = 0;
  localparam int data_ready_irq_enable_pos = 1;
  localparam int marker_irq_enable_pos = 2;
  localparam int stuff_overflow_irq_enable_pos = 3;
  localparam int marker_pause_pos = 7;
  localparam int pixels_high_width = 6;
  localparam int predicted_symbol_pos = 15;

  // ==========================================================================
  // Reset values and sizes
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [15:0] reset_word = 16'h0000;
  localparam logic [15:0] line_count_max = 16'hffff;
  localparam int table_depth = 1024;
  localparam int table_addr_width = 10;
  localparam logic [14:0] probability_min = 15'h0001;
  localparam logic [14:0] probability_max = 15'h5b12;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {
    op_coding = 2'h0,
    op_decoding = 2'h1,
    op_through_image_to_code = 2'h2,
    op_through_code_to_image = 2'h3
  } op_select_t;

  typedef struct packed {
    logic typical_prediction_on;
    logic linemem_init_inhibit;
    logic [1:0] readthrough_bytes;
    logic [1:0] linemem_transfer_select;
    op_select_t op_select;
  } operation_mode_t;

  typedef struct packed {
    logic marker_pause;
    logic [2:0] unused;
    logic stuff_overflow_irq_enable;
    logic marker_irq_enable;
    logic data_ready_irq_enable;
    logic done_irq_enable;
  } interrupt_enable_t;

  typedef struct packed {
    logic done;
    logic data_ready;
    logic marker_found;
    logic stuff_overflow;
    logic temp_stop;
  } core_events_t;

endpackage

// ===== hdl/context_table_ram.sv
// Purpose: Context table storage with registered read data
// Assumes: One write or one read per cycle
// Notes: Contents are not reset
`timescale 1ns/1ps
module context_table_ram #(
  parameter int depth = 1024,
  parameter int addr_width = 10
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [addr_width-1:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data
);

  logic [15:0] mem [depth];

  // ==========================================================================
  // Storage
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end

endmodule

// ===== sim/host_bus_model.sv
// Purpose: Host processor bus model for the coder control registers
// Assumes: Strobes change on the falling clock edge
// Notes: Each access takes two cycles, callers keep values legal
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clock,
  output logic [3:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata
);
  // ==========================================================================
  // Idle levels
  initial
  begin
    host_addr = 4'h0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = 8'h00;
  end

  // ==========================================================================
  // Accesses
  // Pixel, line count, mode and table values come legal from the caller
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clock);
    host_wr = 1'b0;
    host_wdata = ~d; // Stale data must not look valid
  endtask

  // Address held a cycle past the strobe so read data can be sampled
  task automatic rd(input logic [3:0] a);
    @(negedge clock);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clock);
    host_rd = 1'b0;
  endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the coder host control registers
// Assumes: Inputs change on the falling edge
// Notes: Read results checked by a monitor against a queue of notes
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  // ==========================================================================
  // Signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] host_addr;
  logic host_wr, host_rd, start_cmd, pause_select, table_transfer_command, status_clear;
  logic line_step, marker_seen, code_byte_valid, irq_out, run_command, decode_hold;
  logic line_limit_reached, code_byte_discard, rd_seen;
  logic [7:0] host_wdata, host_rdata, exp_v;
  logic [7:0] exp_q[$];
  arith_coder_pkg::core_events_t core_events;
  arith_coder_pkg::operation_mode_t mode_out;
  logic [13:0] pixels_per_line;
  logic [15:0] line_target;
  logic [3:0] status_bits;
  int checks = 0;
  int bad_count = 0;
  int lim_n = 0;
  int disc_n = 0;
  int cyc_n = 0;

  always #2 clock = ~clock;

  host_bus_model host (.clock(clock), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata));

  arith_coder_host_control_regs dut (.clock(clock), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .start_cmd(start_cmd),
    .pause_select(pause_select), .table_transfer_command(table_transfer_command), .core_events(core_events),
    .status_clear(status_clear), .line_step(line_step), .marker_seen(marker_seen),
    .code_byte_valid(code_byte_valid), .irq_out(irq_out), .run_command(run_command), .decode_hold(decode_hold),
    .line_limit_reached(line_limit_reached), .code_byte_discard(code_byte_discard), .mode_out(mode_out),
    .pixels_per_line(pixels_per_line), .line_target(line_target), .status_bits(status_bits));

  // ==========================================================================
  // Monitor, pulse counters and timeout
  always @(posedge clock)
  begin
    rd_seen <= host_rd;
    lim_n <= lim_n + int'(line_limit_reached === 1'b1);
    disc_n <= disc_n + int'(code_byte_discard === 1'b1);
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end

  always @(negedge clock)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(host_rdata, exp_v)
    end

  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host.rd(a);
  endtask

  task automatic start();
    start_cmd = 1'b1;
    cyc(1);
    start_cmd = 1'b0;
    cyc(1);
  endtask

  // Pause or final end after n lines
  task automatic run_lines(input logic p, input int n);
    int b;
    b = lim_n;
    pause_select = p;
    host.wr(4'h6, 8'(n));
    host.wr(4'h7, 8'h00);
    `CHK(line_target, 16'(n))
    start();
    `CHK(run_command, 1'b1)
    rd_exp(4'h8, 8'h00);
    repeat (n)
    begin
      line_step = 1'b1;
      cyc(1);
      line_step = 1'b0;
      cyc(1);
    end
    cyc(2);
    `CHK(lim_n - b, 1)
    rd_exp(4'h8, 8'(n));
    if (p)
      `CHK(irq_out, 1'b1)
    else
      `CHK(run_command, 1'b0)
    `CHK(status_bits[0], 1'b0)
  endtask

  task automatic finish_test();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [13:0] px;
    logic [7:0] v;
    logic [15:0] e[3];
    int b;
    {start_cmd, pause_select, table_transfer_command, status_clear} = 4'h0;
    {line_step, marker_seen, code_byte_valid} = 3'h0;
    core_events = '0;
    void'($urandom(32'hab10));
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    for (int a = 0; a < 16; a++)
      if (a != 10)
        rd_exp(4'(a), 8'h00);
    $display("test reset values done");

    // Readback, read-only write ignored, pixel count within limits
    px = 14'(8 * $urandom_range(1, 1024));
    v = 8'($urandom) & 8'hf7;
    host.wr(4'h4, px[7:0]);
    host.wr(4'h5, {2'b00, px[13:8]});
    host.wr(4'hb, v);
    host.wr(4'h8, 8'h5a);
    rd_exp(4'h4, px[7:0]);
    rd_exp(4'h5, {2'b00, px[13:8]});
    rd_exp(4'hb, v);
    rd_exp(4'h8, 8'h00);
    `CHK(pixels_per_line, px)
    `CHK(mode_out, v)
    for (int m = 0; m < 4; m++)
    begin
      host.wr(4'hb, 8'(m));
      cyc(1);
      `CHK(mode_out.op_select, 2'(m))
    end
    $display("test registers done");

    // Each cause raised, read, masked, unmasked and cleared
    for (int i = 0; i < 4; i++)
    begin
      host.wr(4'h3, 8'(1 << i));
      core_events = 5'(1 << (4 - i));
      cyc(1);
      if (i != 1)
        core_events = '0;
      cyc(2);
      `CHK(irq_out, 1'b1)
      rd_exp(4'h3, 8'(1 << i));
      host.wr(4'h3, 8'h00);
      cyc(2);
      `CHK(irq_out, 1'b0)
      `CHK(status_bits, 4'(1 << i))
      host.wr(4'h3, 8'(1 << i));
      cyc(2);
      `CHK(irq_out, 1'b1)
      core_events = '0;
      status_clear = 1'b1;
      cyc(1);
      status_clear = 1'b0;
      cyc(2);
      `CHK(irq_out, 1'b0)
      `CHK(status_bits, 4'h0)
    end
    $display("test interrupts done");

    // Final end, then temporary stop with done interrupt enabled
    host.wr(4'hb, 8'h00);
    host.wr(4'h3, 8'h01);
    run_lines(1'b0, $urandom_range(2, 6));
    run_lines(1'b1, $urandom_range(2, 6));
    $display("test line counting done");

    // Marker pause during decoding, then resume
    host.wr(4'hb, 8'h01);
    host.wr(4'h3, 8'h84);
    start();
    marker_seen = 1'b1;
    cyc(1);
    marker_seen = 1'b0;
    cyc(2);
    `CHK(decode_hold, 1'b1)
    `CHK(irq_out, 1'b1)
    host.wr(4'h6, 8'hff);
    host.wr(4'h7, 8'hff);
    host.wr(4'h6, 8'h09);
    host.wr(4'h7, 8'h00);
    `CHK(line_target, 16'h0009)
    host.wr(4'h3, 8'h04);
    cyc(2);
    `CHK(decode_hold, 1'b0)
    b = lim_n;
    repeat (9)
    begin
      line_step = 1'b1;
      cyc(1);
      line_step = 1'b0;
      cyc(1);
    end
    cyc(2);
    `CHK(lim_n - b, 1)
    $display("test marker pause done");

    // Every read-through count
    for (int k = 0; k < 4; k++)
    begin
      host.wr(4'hb, {2'b00, 2'(k), 4'h1});
      b = disc_n;
      start();
      repeat (5)
      begin
        code_byte_valid = 1'b1;
        cyc(1);
        code_byte_valid = 1'b0;
        cyc(1);
      end
      `CHK(disc_n - b, k)
    end
    $display("test read-through done");

    // Context table load session, then store session
    table_transfer_command = 1'b1;
    cyc(1);
    for (int k = 0; k < 3; k++)
    begin
      e[k] = {1'($urandom), ((($urandom % 2) != 0) ? 15'h5a1d : 15'h5b12)};
      host.wr(4'ha, e[k][7:0]);
      host.wr(4'ha, e[k][15:8]);
    end
    table_transfer_command = 1'b0;
    cyc(2);
    table_transfer_command = 1'b1;
    cyc(2);
    for (int k = 0; k < 3; k++)
    begin
      rd_exp(4'ha, e[k][7:0]);
      rd_exp(4'ha, e[k][15:8]);
    end
    table_transfer_command = 1'b0;
    cyc(2);
    $display("test context table done");
    finish_test();
  end
endmodule
